// [design/mssx_core.sv]
// Execution unit for subtract, skip, set, swap, table read and xor instructions
`timescale 1ns/1ps
module mssx_core #(
	parameter int PC_W = 11, // Program counter width
	parameter int PW = 14, // Program word width
	parameter int DEPTH = 256 // Data memory bytes
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce, // Low freezes everything
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [PC_W-1:0] prog_addr, // Program memory address
	input wire logic [PW-1:0] prog_data // Word for prog_addr, in the same cycle
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam int TH_W = PW - mssx_pkg::BYTE_W; // High part width
	localparam logic [PC_W-mssx_pkg::BYTE_W-1:0] LAST_PAGE = '1; // Top page number

	mssx_pkg::mssx_state_e state_reg; // Sequencer state
	logic dp_valid_reg; // Data phase pending
	logic dp_write_reg;
	logic [7:0] dp_addr_reg;
	logic rd_done_reg; // Read data already loaded
	logic [31:0] hrdata_reg;
	logic [31:0] rd_mux;
	logic busy;
	logic bus_wr; // Write data phase completes now
	logic [4:0] op_reg;
	logic [2:0] bit_reg;
	logic [7:0] maddr_reg; // Operand byte address
	logic [7:0] imm_reg;
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic [3:0] flags_reg;
	logic [3:0] flags_next;
	logic [7:0] table_pointer_reg;
	logic [TH_W-1:0] table_high_byte_reg;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] prog_addr_reg;
	logic [7:0] win_addr_reg; // Software window into data memory
	logic skip_pending_reg; // Next instruction is to be dropped
	logic [mssx_pkg::CNT_W-1:0] cyc_cnt_reg; // Instruction cycles used
	logic [7:0] mem_rd; // Operand byte
	logic [7:0] win_rd; // Window byte
	logic mem_we;
	logic [7:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic ex_we; // Execution writes memory
	logic [7:0] ex_wdata;
	logic ex_skip;
	logic ex_table_high_byte_reg_we;
	logic [7:0] sub_b;
	logic sub_borrow;
	logic [7:0] sub_diff;
	logic sub_c;
	logic sub_aux;
	logic sub_ovf;
	logic [3:0] sub_flags;
	logic is_exec;

	// ****************************************
	// Helpers
	// ****************************************
	// Zero test shared by skips and the zero flag
	function automatic logic is_zero(input logic [7:0] v);
		return v == mssx_pkg::BYTE_ZERO;
	endfunction : is_zero

	// Zero flag update for a written result
	function automatic logic [3:0] with_zero(input logic [3:0] f, input logic [7:0] r);
		logic [3:0] o;
		o = f;
		o[mssx_pkg::FLAG_Z] = is_zero(r);
		return o;
	endfunction : with_zero

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	assign busy = (state_reg != mssx_pkg::MSSX_IDLE);
	assign is_exec = (state_reg == mssx_pkg::MSSX_EXEC);
	assign hresp = mssx_pkg::HRESP_OKAY;
	assign hrdata = hrdata_reg;

	// Writes wait while an instruction runs, so bus and core never
	// touch the same state in one cycle; reads take one wait state
	always_comb begin
		hreadyout = ce;
		if (dp_valid_reg) begin
			if (dp_write_reg) begin
				hreadyout = ce & ~busy;
			end else begin
				hreadyout = ce & rd_done_reg;
			end
		end
	end

	assign bus_wr = dp_valid_reg & dp_write_reg & hreadyout;

	// Address phase capture
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (ce && hready) begin
			// Only word transfers are expected; hsize is not checked
			dp_valid_reg <= hsel & htrans[1];
			dp_write_reg <= hwrite;
			dp_addr_reg <= haddr[7:0];
		end
	end

	// Read data mux; unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (dp_addr_reg)
			mssx_pkg::ADDR_ACC: begin
				rd_mux[7:0] = acc_reg;
			end
			mssx_pkg::ADDR_FLAGS: begin
				rd_mux[mssx_pkg::FLAG_W-1:0] = flags_reg;
			end
			mssx_pkg::ADDR_STATUS: begin
				rd_mux[mssx_pkg::STAT_BUSY] = busy;
				rd_mux[mssx_pkg::STAT_SKIP] = skip_pending_reg;
				rd_mux[mssx_pkg::STAT_CNT_LSB +: mssx_pkg::CNT_W] = cyc_cnt_reg;
			end
			mssx_pkg::ADDR_TPTR: begin
				rd_mux[7:0] = table_pointer_reg;
			end
			mssx_pkg::ADDR_THIGH: begin
				rd_mux[TH_W-1:0] = table_high_byte_reg;
			end
			mssx_pkg::ADDR_MADDR: begin
				rd_mux[7:0] = win_addr_reg;
			end
			mssx_pkg::ADDR_MDATA: begin
				rd_mux[7:0] = win_rd;
			end
			mssx_pkg::ADDR_PC: begin
				rd_mux[PC_W-1:0] = pc_reg;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Read data register, loaded in the wait state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hrdata_reg <= 32'h0000_0000;
			rd_done_reg <= 1'b0;
		end else if (ce) begin
			if (dp_valid_reg && !dp_write_reg && !rd_done_reg) begin
				hrdata_reg <= rd_mux;
				rd_done_reg <= 1'b1;
			end else begin
				rd_done_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Datapath
	// ****************************************
	// Immediate form subtracts imm, borrow form also subtracts not-carry
	assign sub_b = (op_reg == mssx_pkg::OP_SUB_IMM) ? imm_reg : mem_rd;
	assign sub_borrow = (op_reg == mssx_pkg::OP_SUB_BORROW_TO_MEM) & ~flags_reg[mssx_pkg::FLAG_C];

	mssx_sub u_sub (
		.a(acc_reg),
		.b(sub_b),
		.borrow_in(sub_borrow),
		.diff(sub_diff),
		.carry(sub_c),
		.aux_carry(sub_aux),
		.overflow(sub_ovf)
	);

	// All four arithmetic flags from one subtraction
	always_comb begin
		sub_flags = flags_reg;
		sub_flags[mssx_pkg::FLAG_C] = sub_c;
		sub_flags[mssx_pkg::FLAG_AUX] = sub_aux;
		sub_flags[mssx_pkg::FLAG_OVF] = sub_ovf;
		sub_flags[mssx_pkg::FLAG_Z] = is_zero(sub_diff);
	end

	// Instruction execute; results only commit in the EXEC cycle
	always_comb begin
		acc_next = acc_reg;
		flags_next = flags_reg;
		ex_we = 1'b0;
		ex_wdata = mem_rd;
		ex_skip = 1'b0;
		ex_table_high_byte_reg_we = 1'b0;
		case (op_reg)
			mssx_pkg::OP_SUB_ACC: begin
				acc_next = sub_diff;
				flags_next = sub_flags;
			end
			mssx_pkg::OP_SUB_TO_MEM: begin
				ex_we = 1'b1;
				ex_wdata = sub_diff;
				flags_next = sub_flags;
			end
			mssx_pkg::OP_SUB_IMM: begin
				acc_next = sub_diff;
				flags_next = sub_flags;
			end
			mssx_pkg::OP_SUB_BORROW_TO_MEM: begin
				ex_we = 1'b1;
				ex_wdata = sub_diff;
				flags_next = sub_flags;
			end
			mssx_pkg::OP_DEC_SKIP_ZERO: begin
				ex_we = 1'b1;
				ex_wdata = mem_rd - mssx_pkg::BYTE_ONE;
				ex_skip = is_zero(ex_wdata);
			end
			mssx_pkg::OP_DEC_SKIP_ZERO_TO_ACC: begin
				acc_next = mem_rd - mssx_pkg::BYTE_ONE;
				ex_skip = is_zero(acc_next);
			end
			mssx_pkg::OP_INC_SKIP_ZERO: begin
				ex_we = 1'b1;
				ex_wdata = mem_rd + mssx_pkg::BYTE_ONE;
				ex_skip = is_zero(ex_wdata);
			end
			mssx_pkg::OP_INC_SKIP_ZERO_TO_ACC: begin
				acc_next = mem_rd + mssx_pkg::BYTE_ONE;
				ex_skip = is_zero(acc_next);
			end
			mssx_pkg::OP_SET_BYTE: begin
				ex_we = 1'b1;
				ex_wdata = mssx_pkg::BYTE_ALL_ONES;
			end
			mssx_pkg::OP_SET_BIT: begin
				ex_we = 1'b1;
				ex_wdata = mem_rd | (mssx_pkg::BYTE_ONE << bit_reg);
			end
			mssx_pkg::OP_SKIP_BIT_SET: begin
				ex_skip = mem_rd[bit_reg];
			end
			mssx_pkg::OP_SKIP_BIT_CLEAR: begin
				ex_skip = ~mem_rd[bit_reg];
			end
			mssx_pkg::OP_NIBBLE_EXCHANGE: begin
				ex_we = 1'b1;
				ex_wdata = {mem_rd[mssx_pkg::NIB_W-1:0],
					mem_rd[mssx_pkg::BYTE_W-1:mssx_pkg::NIB_W]};
			end
			mssx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
				acc_next = {mem_rd[mssx_pkg::NIB_W-1:0],
					mem_rd[mssx_pkg::BYTE_W-1:mssx_pkg::NIB_W]};
			end
			mssx_pkg::OP_SKIP_IF_ZERO: begin
				ex_skip = is_zero(mem_rd);
			end
			mssx_pkg::OP_COPY_SKIP_IF_ZERO: begin
				acc_next = mem_rd;
				ex_skip = is_zero(mem_rd);
			end
			mssx_pkg::OP_TABLE_READ_CURRENT_PAGE,
			mssx_pkg::OP_TABLE_READ_LAST_PAGE: begin
				ex_we = 1'b1;
				ex_wdata = prog_data[mssx_pkg::BYTE_W-1:0];
				ex_table_high_byte_reg_we = 1'b1;
			end
			mssx_pkg::OP_XOR_ACC: begin
				acc_next = acc_reg ^ mem_rd;
				flags_next = with_zero(flags_reg, acc_next);
			end
			mssx_pkg::OP_XOR_IMM: begin
				acc_next = acc_reg ^ imm_reg;
				flags_next = with_zero(flags_reg, acc_next);
			end
			mssx_pkg::OP_XOR_TO_MEM: begin
				ex_we = 1'b1;
				ex_wdata = acc_reg ^ mem_rd;
				flags_next = with_zero(flags_reg, ex_wdata);
			end
			default: begin
				// Unknown codes act as a no-op
				ex_skip = 1'b0;
			end
		endcase
	end

	// Memory write: core in EXEC, software otherwise (never both)
	assign mem_we = (is_exec & ex_we) | (bus_wr & (dp_addr_reg == mssx_pkg::ADDR_MDATA));
	assign mem_waddr = is_exec ? maddr_reg : win_addr_reg;
	assign mem_wdata = is_exec ? ex_wdata : hwdata[7:0];

	mssx_dmem #(
		.DEPTH(DEPTH)
	) u_dmem (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.ce(ce),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr_a(maddr_reg),
		.rdata_a(mem_rd),
		.raddr_b(win_addr_reg),
		.rdata_b(win_rd)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	// A skipping instruction costs a dummy cycle after its own
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= mssx_pkg::MSSX_IDLE;
		end else if (ce) begin
			case (state_reg)
				mssx_pkg::MSSX_IDLE: begin
					if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_CMD && !skip_pending_reg) begin
						state_reg <= mssx_pkg::MSSX_EXEC;
					end
				end
				mssx_pkg::MSSX_EXEC: begin
					state_reg <= ex_skip ? mssx_pkg::MSSX_DUMMY : mssx_pkg::MSSX_IDLE;
				end
				mssx_pkg::MSSX_DUMMY: begin
					state_reg <= mssx_pkg::MSSX_IDLE;
				end
				default: begin
					state_reg <= mssx_pkg::MSSX_IDLE;
				end
			endcase
		end
	end

	// Pending skip: set by a skipping instruction, used up by the next one
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			skip_pending_reg <= 1'b0;
		end else if (ce) begin
			if (is_exec && ex_skip) begin
				skip_pending_reg <= 1'b1;
			end else if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_CMD) begin
				skip_pending_reg <= 1'b0;
			end
		end
	end

	// Instruction latch; a dropped instruction is never latched
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			op_reg <= mssx_pkg::OP_NOP;
			bit_reg <= 3'h0;
			maddr_reg <= 8'h00;
			imm_reg <= 8'h00;
			prog_addr_reg <= '0;
		end else if (ce && bus_wr && dp_addr_reg == mssx_pkg::ADDR_CMD && !skip_pending_reg) begin
			op_reg <= hwdata[mssx_pkg::CMD_OP_LSB +: mssx_pkg::CMD_OP_W];
			bit_reg <= hwdata[mssx_pkg::CMD_BIT_LSB +: 3];
			maddr_reg <= hwdata[mssx_pkg::CMD_MA_LSB +: mssx_pkg::BYTE_W];
			imm_reg <= hwdata[mssx_pkg::CMD_IMM_LSB +: mssx_pkg::BYTE_W];
			if (hwdata[mssx_pkg::CMD_OP_LSB +: mssx_pkg::CMD_OP_W]
				== mssx_pkg::OP_TABLE_READ_LAST_PAGE) begin
				prog_addr_reg <= {LAST_PAGE, table_pointer_reg};
			end else begin
				prog_addr_reg <= {pc_reg[PC_W-1:mssx_pkg::BYTE_W], table_pointer_reg};
			end
		end
	end

	assign prog_addr = prog_addr_reg;

	// Program counter: every instruction taken, run or dropped, steps it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pc_reg <= '0;
		end else if (ce && bus_wr) begin
			if (dp_addr_reg == mssx_pkg::ADDR_CMD) begin
				pc_reg <= pc_reg + 1'b1;
			end else if (dp_addr_reg == mssx_pkg::ADDR_PC) begin
				pc_reg <= hwdata[PC_W-1:0];
			end
		end
	end

	// Instruction cycle counter, wraps
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cyc_cnt_reg <= '0;
		end else if (ce && busy) begin
			cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
		end
	end

	// ****************************************
	// Architectural registers
	// ****************************************
	// Accumulator and flags: core in EXEC, software writes when idle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			acc_reg <= mssx_pkg::BYTE_ZERO;
			flags_reg <= mssx_pkg::FLAGS_RST;
		end else if (ce) begin
			if (is_exec) begin
				acc_reg <= acc_next;
				flags_reg <= flags_next;
			end else if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_ACC) begin
				acc_reg <= hwdata[7:0];
			end else if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_FLAGS) begin
				flags_reg <= hwdata[mssx_pkg::FLAG_W-1:0];
			end
		end
	end

	// Table pointer, table high part and memory window address
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			table_pointer_reg <= 8'h00;
			table_high_byte_reg <= '0;
			win_addr_reg <= 8'h00;
		end else if (ce) begin
			if (is_exec && ex_table_high_byte_reg_we) begin
				table_high_byte_reg <= prog_data[PW-1:mssx_pkg::BYTE_W];
			end
			if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_TPTR) begin
				table_pointer_reg <= hwdata[7:0];
			end
			if (bus_wr && dp_addr_reg == mssx_pkg::ADDR_MADDR) begin
				win_addr_reg <= hwdata[7:0];
			end
		end
	end

	// hsize is taken but unused: only word access is supported
	logic unused_hsize;
	assign unused_hsize = ^hsize;
endmodule : mssx_core

// [inc/mssx_pkg.sv]
// Constants, opcodes and register map of the skip/subtract/xor execution unit
//
// Overview of operation
// - Borrow subtract to memory; carry means no borrow
// - Subtract to accumulator or memory, four flags
// - Subtract immediate from accumulator, carry means nonnegative
// - Decrement memory, skip next when zero
// - Inc/dec into accumulator, memory kept, skip zero
// - Increment memory, skip next when zero
// - Skipping adds one dummy instruction cycle
// - Set byte writes all ones, flags kept
// - Set bit forces one bit high
// - Skip next when selected bit is one
// - Skip next when selected bit is zero
// - Swap nibbles in memory or into accumulator
// - Skip next when memory byte is zero
// - Copy byte to accumulator, skip if zero
// - Table read current page, low/high split
// - Table read last page, low/high split
// - Xor into accumulator, zero flag only
// - Xor into memory, zero flag only
package mssx_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CMD = 8'h00; // Write launches one instruction unless a skip is pending
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_TPTR = 8'h10;
	localparam logic [7:0] ADDR_THIGH = 8'h14;
	localparam logic [7:0] ADDR_MADDR = 8'h18;
	localparam logic [7:0] ADDR_MDATA = 8'h1c;
	localparam logic [7:0] ADDR_PC = 8'h20;
	// ****************************************
	// Field layouts
	// ****************************************
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 5;
	localparam int CMD_BIT_LSB = 5;
	localparam int CMD_MA_LSB = 8;
	localparam int CMD_IMM_LSB = 16;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int FLAG_W = 4;
	localparam int FLAG_C = 0;
	localparam int FLAG_AUX = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OVF = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SKIP = 1;
	localparam int STAT_CNT_LSB = 16;
	localparam int CNT_W = 16;
	// ****************************************
	// Values
	// ****************************************
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic HRESP_OKAY = 1'b0;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [4:0] OP_NOP = 5'h00;
	localparam logic [4:0] OP_SUB_ACC = 5'h01;
	localparam logic [4:0] OP_SUB_TO_MEM = 5'h02;
	localparam logic [4:0] OP_SUB_IMM = 5'h03;
	localparam logic [4:0] OP_SUB_BORROW_TO_MEM = 5'h04;
	localparam logic [4:0] OP_DEC_SKIP_ZERO = 5'h05;
	localparam logic [4:0] OP_DEC_SKIP_ZERO_TO_ACC = 5'h06;
	localparam logic [4:0] OP_INC_SKIP_ZERO = 5'h07;
	localparam logic [4:0] OP_INC_SKIP_ZERO_TO_ACC = 5'h08;
	localparam logic [4:0] OP_SET_BYTE = 5'h09;
	localparam logic [4:0] OP_SET_BIT = 5'h0a;
	localparam logic [4:0] OP_SKIP_BIT_SET = 5'h0b;
	localparam logic [4:0] OP_SKIP_BIT_CLEAR = 5'h0c;
	localparam logic [4:0] OP_NIBBLE_EXCHANGE = 5'h0d;
	localparam logic [4:0] OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0e;
	localparam logic [4:0] OP_SKIP_IF_ZERO = 5'h0f;
	localparam logic [4:0] OP_COPY_SKIP_IF_ZERO = 5'h10;
	localparam logic [4:0] OP_TABLE_READ_CURRENT_PAGE = 5'h11;
	localparam logic [4:0] OP_TABLE_READ_LAST_PAGE = 5'h12;
	localparam logic [4:0] OP_XOR_ACC = 5'h13;
	localparam logic [4:0] OP_XOR_IMM = 5'h14;
	localparam logic [4:0] OP_XOR_TO_MEM = 5'h15;
	// Execution sequencer states
	typedef enum logic [1:0] {MSSX_IDLE, MSSX_EXEC, MSSX_DUMMY} mssx_state_e;
endpackage : mssx_pkg

// [design/mssx_sub.sv]
// Eight-bit subtractor with carry, aux-carry and overflow outputs
`timescale 1ns/1ps
module mssx_sub (
	input wire logic [7:0] a, // Minuend, the accumulator
	input wire logic [7:0] b, // Subtrahend
	input wire logic borrow_in, // Extra one to take away
	output logic [7:0] diff,
	output logic carry, // High means no borrow
	output logic aux_carry, // High means no borrow out of low nibble
	output logic overflow // Signed overflow
);
	logic [8:0] full;
	logic [4:0] low;
	// Ninth bit is the borrow; carry is its inverse
	assign full = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
	assign low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
	assign diff = full[7:0];
	assign carry = ~full[8];
	assign aux_carry = ~low[4];
	// Operands of unlike sign and result sign unlike the minuend
	assign overflow = (a[7] ^ b[7]) & (a[7] ^ full[7]);
endmodule : mssx_sub

// [design/mssx_dmem.sv]
// Flip-flop data memory, one write port and two read ports
`timescale 1ns/1ps
module mssx_dmem #(
	parameter int DEPTH = 256
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [7:0] raddr_b,
	output logic [7:0] rdata_b
);
	logic [7:0] mem [DEPTH];
	// One flop byte per entry, cleared at reset
	for (genvar i = 0; i < DEPTH; i++) begin : g_byte
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				mem[i] <= mssx_pkg::BYTE_ZERO;
			end else if (ce && we && (waddr == 8'(i))) begin
				mem[i] <= wdata;
			end
		end
	end
	// Addresses past the end read as zero
	assign rdata_a = (int'(raddr_a) < DEPTH) ? mem[raddr_a] : mssx_pkg::BYTE_ZERO;
	assign rdata_b = (int'(raddr_b) < DEPTH) ? mem[raddr_b] : mssx_pkg::BYTE_ZERO;
endmodule : mssx_dmem

// [tb/mssx_sva.sv]
// Bus and program-port checks for the execution unit
`timescale 1ns/1ps
module mssx_sva #(
	parameter int PC_W = 11
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [PC_W-1:0] prog_addr
);
	logic tk; // Address phase taken
	logic dp; // Data phase open
	logic dw; // Open phase is a write
	logic [7:0] da; // Its address
	logic rd; // Read data on the bus
	assign tk = hsel & htrans[1] & hready & ce;
	assign rd = dp & !dw & hreadyout;
	// Follow the open data phase; a taken phase wins over the close
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dp <= 1'b0;
			dw <= 1'b0;
			da <= 8'h00;
		end else if (tk) begin
			dp <= 1'b1;
			dw <= hwrite;
			da <= haddr[7:0];
		end else if (hreadyout) begin
			dp <= 1'b0;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	AST_OKAY: assert property (hresp == mssx_pkg::HRESP_OKAY)
		else $error("response not okay");
	AST_FROZEN: assert property (!ce |-> !hreadyout)
		else $error("ready while frozen");
	AST_RD_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	AST_EXEC_BUSY: assert property (dp && dw && da == mssx_pkg::ADDR_CMD && tk && hwrite |=> !hreadyout)
		else $error("write after command not stalled");
	AST_WR_STALL: assert property (dp && dw |-> ##[0:2] hreadyout)
		else $error("write stalled too long");
	AST_HOLD: assert property ($changed(hrdata) |-> $past(dp && !dw))
		else $error("read data moved outside a read");
	AST_RST_PC: assert property ($rose(resetn) |-> prog_addr == {PC_W{1'b0}})
		else $error("program address not cleared");
	AST_RD_ACC: assert property (rd && da == mssx_pkg::ADDR_ACC |-> hrdata[31:8] == 24'h0)
		else $error("accumulator upper bits set");
	AST_RD_FLAGS: assert property (rd && da == mssx_pkg::ADDR_FLAGS |-> hrdata[31:4] == 28'h0)
		else $error("flag upper bits set");
	AST_RD_THIGH: assert property (rd && da == mssx_pkg::ADDR_THIGH |-> hrdata[31:6] == 26'h0)
		else $error("table high upper bits set");
	AST_RD_ZERO: assert property (rd && (da == mssx_pkg::ADDR_CMD || da > mssx_pkg::ADDR_PC)
		|-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	// Skip stall, plain read, table high read
	cover property (dp && dw && !hreadyout ##1 !hreadyout);
	cover property (rd);
	cover property (rd && da == mssx_pkg::ADDR_THIGH);
endmodule : mssx_sva

// [tb/testbench.sv]
// Register-level bench for the execution unit
`timescale 1ns/1ps
module testbench;
	logic clk_sys, resetn, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [10:0] prog_addr;
	logic [13:0] prog_data, w;
	int err_count, tests_run;
	// Program word model, high part differs per page
	function automatic logic [13:0] rom(input logic [10:0] a);
		return {a[10:5], a[7:0] ^ 8'h5a};
	endfunction : rom
	assign hready = hreadyout;
	assign prog_data = rom(prog_addr);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	mssx_core #(.PC_W(11), .PW(14), .DEPTH(256)) dut (.clk_sys(clk_sys), .resetn(resetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .prog_addr(prog_addr), .prog_data(prog_data));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Ready is settled at the falling edge, so read it there
	task automatic wt();
		logic r;
		int n;
		r = 1'b0;
		n = 0;
		while (r !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			r = hreadyout;
			q = hrdata;
			@(posedge clk_sys);
			n++;
		end
		if (r !== 1'b1) chk(32'h0, 32'h1);
	endtask : wt
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wt();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wt();
	endtask : xfer
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc
	// s and e pack memory byte, accumulator and flags
	task automatic run(input logic [4:0] op, input logic [7:0] x, input logic [19:0] s,
		input logic [19:0] e, input logic sk);
		logic [15:0] c;
		xfer(1'b1, mssx_pkg::ADDR_MADDR, 32'h42);
		xfer(1'b1, mssx_pkg::ADDR_MDATA, {24'h0, s[19:12]});
		xfer(1'b1, mssx_pkg::ADDR_ACC, {24'h0, s[11:4]});
		xfer(1'b1, mssx_pkg::ADDR_FLAGS, {28'h0, s[3:0]});
		xfer(1'b0, mssx_pkg::ADDR_STATUS, 32'h0);
		c = q[31:16] + {15'h0, sk} + 16'h1;
		xfer(1'b1, mssx_pkg::ADDR_CMD, {8'h0, x, 8'h42, x[2:0], op});
		xfer(1'b1, mssx_pkg::ADDR_MADDR, 32'h42);
		rdc(mssx_pkg::ADDR_STATUS, {c, 14'h0, sk, 1'b0});
		rdc(mssx_pkg::ADDR_ACC, {24'h0, e[11:4]});
		rdc(mssx_pkg::ADDR_FLAGS, {28'h0, e[3:0]});
		rdc(mssx_pkg::ADDR_MDATA, {24'h0, e[19:12]});
		if (sk) begin
			xfer(1'b1, mssx_pkg::ADDR_CMD, {16'h00ff, 11'h210, mssx_pkg::OP_XOR_IMM});
			rdc(mssx_pkg::ADDR_STATUS, {c, 16'h0});
			rdc(mssx_pkg::ADDR_ACC, {24'h0, e[11:4]});
		end
	endtask : run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// Watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 10; i++) rdc(8'(4 * i), 32'h0);
		xfer(1'b1, mssx_pkg::ADDR_THIGH, 32'h3f);
		xfer(1'b1, 8'h30, 32'hffff);
		xfer(1'b1, mssx_pkg::ADDR_ACC, 32'hffffff12);
		rdc(mssx_pkg::ADDR_THIGH, 32'h0);
		rdc(8'h30, 32'h0);
		rdc(mssx_pkg::ADDR_ACC, 32'h12);
		ce <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({31'h0, hreadyout}, 32'h0);
		@(posedge clk_sys);
		ce <= 1'b1;
		rdc(mssx_pkg::ADDR_ACC, 32'h12);
		$display("test reset and bus done");
		run(mssx_pkg::OP_SUB_ACC, 8'h00, 20'h20_10_0, 20'h20_f0_2, 1'b0);
		run(mssx_pkg::OP_SUB_TO_MEM, 8'h00, 20'h01_80_0, 20'h7f_80_9, 1'b0);
		run(mssx_pkg::OP_SUB_IMM, 8'h35, 20'h77_35_0, 20'h77_00_7, 1'b0);
		run(mssx_pkg::OP_SUB_IMM, 8'h20, 20'h77_10_0, 20'h77_f0_2, 1'b0);
		run(mssx_pkg::OP_SUB_BORROW_TO_MEM, 8'h00, 20'h05_05_0, 20'hff_05_0, 1'b0);
		run(mssx_pkg::OP_SUB_BORROW_TO_MEM, 8'h00, 20'h05_05_1, 20'h00_05_7, 1'b0);
		$display("test subtract done");
		run(mssx_pkg::OP_DEC_SKIP_ZERO, 8'h00, 20'h01_33_f, 20'h00_33_f, 1'b1);
		run(mssx_pkg::OP_DEC_SKIP_ZERO, 8'h00, 20'h00_33_f, 20'hff_33_f, 1'b0);
		run(mssx_pkg::OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 20'h01_33_f, 20'h01_00_f, 1'b1);
		run(mssx_pkg::OP_INC_SKIP_ZERO, 8'h00, 20'hff_33_0, 20'h00_33_0, 1'b1);
		run(mssx_pkg::OP_INC_SKIP_ZERO, 8'h00, 20'h07_33_0, 20'h08_33_0, 1'b0);
		run(mssx_pkg::OP_INC_SKIP_ZERO_TO_ACC, 8'h00, 20'hff_33_0, 20'hff_00_0, 1'b1);
		run(mssx_pkg::OP_INC_SKIP_ZERO_TO_ACC, 8'h00, 20'h10_33_0, 20'h10_11_0, 1'b0);
		$display("test step and skip done");
		run(mssx_pkg::OP_SET_BYTE, 8'h00, 20'h12_33_a, 20'hff_33_a, 1'b0);
		run(mssx_pkg::OP_SET_BIT, 8'h07, 20'h01_33_5, 20'h81_33_5, 1'b0);
		run(mssx_pkg::OP_SKIP_BIT_SET, 8'h03, 20'h08_33_0, 20'h08_33_0, 1'b1);
		run(mssx_pkg::OP_SKIP_BIT_SET, 8'h03, 20'hf7_33_0, 20'hf7_33_0, 1'b0);
		run(mssx_pkg::OP_SKIP_BIT_CLEAR, 8'h00, 20'hfe_33_0, 20'hfe_33_0, 1'b1);
		run(mssx_pkg::OP_SKIP_BIT_CLEAR, 8'h00, 20'h01_33_0, 20'h01_33_0, 1'b0);
		run(mssx_pkg::OP_NIBBLE_EXCHANGE, 8'h00, 20'h3c_33_0, 20'hc3_33_0, 1'b0);
		run(mssx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 8'h00, 20'ha5_33_0, 20'ha5_5a_0, 1'b0);
		run(mssx_pkg::OP_SKIP_IF_ZERO, 8'h00, 20'h00_33_0, 20'h00_33_0, 1'b1);
		run(mssx_pkg::OP_SKIP_IF_ZERO, 8'h00, 20'h40_33_0, 20'h40_33_0, 1'b0);
		run(mssx_pkg::OP_COPY_SKIP_IF_ZERO, 8'h00, 20'h00_33_0, 20'h00_00_0, 1'b1);
		run(mssx_pkg::OP_COPY_SKIP_IF_ZERO, 8'h00, 20'h99_33_0, 20'h99_99_0, 1'b0);
		$display("test bit and byte done");
		run(mssx_pkg::OP_XOR_ACC, 8'h00, 20'h5a_5a_b, 20'h5a_00_f, 1'b0);
		run(mssx_pkg::OP_XOR_IMM, 8'hf0, 20'h77_0f_f, 20'h77_ff_b, 1'b0);
		run(mssx_pkg::OP_XOR_TO_MEM, 8'h00, 20'h0f_33_4, 20'h3c_33_0, 1'b0);
		xfer(1'b1, mssx_pkg::ADDR_PC, 32'h345);
		xfer(1'b1, mssx_pkg::ADDR_TPTR, 32'h9c);
		w = rom(11'h39c);
		run(mssx_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h00, 20'h11_22_5, {w[7:0], 12'h22_5}, 1'b0);
		rdc(mssx_pkg::ADDR_THIGH, {26'h0, w[13:8]});
		w = rom(11'h79c);
		run(mssx_pkg::OP_TABLE_READ_LAST_PAGE, 8'h00, 20'h11_22_5, {w[7:0], 12'h22_5}, 1'b0);
		rdc(mssx_pkg::ADDR_THIGH, {26'h0, w[13:8]});
		// Write pipelined behind a skipping command waits out EXEC and DUMMY
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		haddr <= 32'h0;
		wt();
		hwdata <= {27'h0, mssx_pkg::OP_SKIP_IF_ZERO};
		xfer(1'b1, mssx_pkg::ADDR_ACC, 32'h77);
		rdc(mssx_pkg::ADDR_ACC, 32'h77);
		xfer(1'b0, mssx_pkg::ADDR_STATUS, 32'h0);
		chk({30'h0, q[1:0]}, 32'h2);
		$display("test xor and table done");
		conclude();
	end
endmodule : testbench
bind mssx_core mssx_sva #(.PC_W(PC_W)) u_sva (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_addr(prog_addr));
